// *** flash_array_model.sv ***
// flash_array_model: behavioural word array behind the controller's array port
// assumes arrReq, op, address and data stay put until the arrAck edge
`timescale 1ns/1ps
module flash_array_model
	import flash_ctrl_pkg::*;
(
	// clock and stall control
	input wire logic mclk,
	input wire logic slowAck,
	// array port
	input wire logic arrReq,
	input wire logic [1:0] arrOp,
	input wire logic [13:0] arrAddr,
	input wire logic [31:0] arrWdata,
	output logic [31:0] arrRdata,
	output logic arrAck
);
	logic [31:0] mem [16384];
	int waitCnt;
	initial begin
		foreach (mem[i]) mem[i] = '1;
		arrAck = 1'b0;
		arrRdata = '0;
		forever begin
			@(posedge mclk);
			if (!(arrReq && !arrAck)) begin
				arrAck <= 1'b0;
				// stale read data never lingers
				arrRdata <= ~arrRdata;
			end else begin
				waitCnt = slowAck ? 20 : $urandom_range(2);
				if (waitCnt > 0) begin
					arrAck <= 1'b0;
					arrRdata <= ~arrRdata;
					repeat (waitCnt) @(posedge mclk);
				end
				if (arrOp == ARR_WRITE) mem[arrAddr] = mem[arrAddr] & arrWdata;
				if (arrOp == ARR_PAGE_ERASE) for (int i = 0; i < 256; i++) mem[{arrAddr[13:8], 8'(i)}] = '1;
				if (arrOp == ARR_MASS_ERASE) foreach (mem[j]) mem[j] = '1;
				arrRdata <= mem[arrAddr];
				arrAck <= 1'b1;
			end
		end
	end
endmodule : flash_array_model

// *** flash_ctrl_chk.sv ***
// flash_ctrl_chk: port assertions for the flash program/erase controller
// assumes the bind below; the active level is codeOptionLevel taken at boot
`timescale 1ns/1ps
module flash_ctrl_chk
	import flash_ctrl_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	// flash space and levels
	input wire logic fReq,
	input wire logic fWrite,
	input wire logic [1:0] fPath,
	input wire logic fReady,
	input wire logic fDenied,
	input wire logic [1:0] codeOptionLevel,
	input wire logic [1:0] storedLevel,
	input wire logic [1:0] powerSavingMode,
	// array
	input wire logic arrReq,
	input wire logic [1:0] arrOp,
	input wire logic [13:0] arrAddr,
	input wire logic [31:0] arrRdata,
	input wire logic arrAck
);
	logic [1:0] upCnt_q;
	logic [1:0] bootLevel_q;
	wire logic keyWr = psel && penable && pwrite && paddr == OFS_POWER_SAVING_CTRL;
	wire logic keyOk = pwdata[31:KEY_LSB] == WRITE_UNLOCK_KEY;
	wire logic modeOk = pwdata[1:0] == PSAVE_DISABLED || pwdata[1:0] == PSAVE_SLOW;
	wire logic massAck = arrAck && arrOp == ARR_MASS_ERASE;
	wire logic longOp = arrReq && arrOp != ARR_READ;
	always_ff @(posedge mclk or negedge nrst)
		if (!nrst) upCnt_q <= 2'h0;
		else if (upCnt_q != 2'h3) upCnt_q <= upCnt_q + 2'h1;
	// level in force since the last boot
	always_ff @(posedge mclk) if (upCnt_q == 2'h0) bootLevel_q <= codeOptionLevel;
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	chk_key_ignored: assert property (keyWr && !keyOk |=> $stable(powerSavingMode))
		else $error("mode changed without key");
	chk_key_applies: assert property (keyWr && keyOk && modeOk
		|=> powerSavingMode == $past(pwdata[1:0])) else $error("keyed mode not taken");
	chk_busy_shows: assert property (psel && !pwrite && paddr == OFS_OPERATION_STATE && longOp
		|-> prdata[ST_BUSY]) else $error("busy low during operation");
	chk_stall_reads: assert property (longOp |-> !fReady) else $error("answer while busy");
	chk_precheck_first: assert property (arrReq && arrOp == ARR_WRITE && $past(arrOp) != ARR_WRITE
		|-> $past(arrAck) && $past(arrRdata) == ERASED_WORD && $stable(arrAddr))
		else $error("write without erased precheck");
	chk_erase_before: assert property (bootLevel_q != UNPROTECTED_LEVEL && upCnt_q == 2'h3
		&& storedLevel == UNPROTECTED_LEVEL && $past(storedLevel) != UNPROTECTED_LEVEL
		|-> $past(massAck) || $past(massAck, 2)) else $error("level cleared before mass erase");
	chk_level_denies: assert property (fReady && fReq && bootLevel_q != UNPROTECTED_LEVEL
		&& (fPath == PATH_DEBUG || (fPath == PATH_PROGRAMMER && !fWrite)) |-> fDenied)
		else $error("protected access allowed");
	chk_arr_hold: assert property (arrReq && !arrAck |=> arrReq && $stable(arrOp) && $stable(arrAddr))
		else $error("array request moved");
endmodule : flash_ctrl_chk
bind flash_program_erase_controller flash_ctrl_chk i_chk (.mclk(mclk), .nrst(nrst), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.fReq(fReq), .fWrite(fWrite), .fPath(fPath), .fReady(fReady), .fDenied(fDenied),
	.codeOptionLevel(codeOptionLevel), .storedLevel(storedLevel),
	.powerSavingMode(powerSavingMode), .arrReq(arrReq), .arrOp(arrOp), .arrAddr(arrAddr),
	.arrRdata(arrRdata), .arrAck(arrAck));

// *** flash_ctrl_pkg.sv ***
// flash_ctrl_pkg: register map, field positions, keys and codes of the flash controller
// assumes a 32-bit apb register bus and a word-wide flash array of 16k words
package flash_ctrl_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_POWER_SAVING_CTRL = 8'h00;
	localparam logic [7:0] OFS_OPERATION_STATE = 8'h04;
	localparam logic [7:0] OFS_OPERATION_SELECT = 8'h08;
	localparam logic [7:0] OFS_TARGET_ADDRESS = 8'h10;
	localparam logic [7:0] OFS_ROM_CHECKSUM = 8'h14;
	localparam logic [7:0] OFS_SECURITY_LEVEL = 8'h18;
	// power saving control fields
	localparam int KEY_LSB = 16;
	localparam logic [15:0] WRITE_UNLOCK_KEY = 16'h5afa;
	localparam logic [1:0] PSAVE_DISABLED = 2'h0;
	localparam logic [1:0] PSAVE_SLOW = 2'h2;
	// status fields
	localparam int ST_BUSY = 0;
	localparam int ST_PROGRAM_ERROR = 2;
	localparam int ST_END_OF_OPERATION = 5;
	// control fields
	localparam int CT_PROGRAM_SELECT = 0;
	localparam int CT_PAGE_ERASE_SELECT = 1;
	localparam int CT_ERASE_START = 6;
	localparam int CT_CHECKSUM_SELECT = 7;
	// security level register fields
	localparam int SEC_ACTIVE_LSB = 4;
	// security levels
	localparam logic [1:0] UNPROTECTED_LEVEL = 2'h0;
	localparam logic [1:0] PROTECT_LEVEL_ONE = 2'h1;
	localparam logic [1:0] PROTECT_LEVEL_TWO = 2'h2;
	localparam logic [1:0] PROTECT_LEVEL_THREE = 2'h3;
	// requesting paths of the flash space port
	localparam logic [1:0] PATH_FIRMWARE = 2'h0;
	localparam logic [1:0] PATH_DEBUG = 2'h1;
	localparam logic [1:0] PATH_PROGRAMMER = 2'h2;
	// array operations
	localparam logic [1:0] ARR_READ = 2'h0;
	localparam logic [1:0] ARR_WRITE = 2'h1;
	localparam logic [1:0] ARR_PAGE_ERASE = 2'h2;
	localparam logic [1:0] ARR_MASS_ERASE = 2'h3;
	// user rom geometry
	localparam int ROM_BYTES = 65536;
	localparam int PAGE_COUNT = 64;
	localparam int PAGE_BYTES = 1024;
	localparam logic [31:0] ERASED_WORD = 32'hffffffff;
	localparam logic [31:0] RESET_ZERO = 32'h00000000;
endpackage : flash_ctrl_pkg

// *** flash_program_erase_controller.sv ***
// flash_program_erase_controller: program/erase sequencer, code security and checksum
// assumes an apb master on mclk and a flash array that answers arrReq with a one-cycle arrAck
//
// Functional notes
// R1: security change acts only after next reboot
// R2: four levels; reads refused above zero, fw at three
// R3: programmer erase returns level to zero; the code ignores it at level three
// R4: downgrade to zero mass erases before level update
// R5: no downgrade requests while debugging; the code takes a downgrade write only when idle
// R6: one 32-bit word per program write
// R7: pre-read target; not erased skips, flags error
// R8: error bit 2 on illegal address; write zero clears
// R9: program completion sets end-of-operation bit
// R10: software: select, write word, poll busy
// R11: software: select, address, start, wait busy
// R12: page erase and hardware mass erase
// R13: checksum stays readable under read protection
// R14: power register write needs key 0x5afa
// R15: mode 00 disabled, 10 slow saving
// R16: busy rises at start, falls at end/error
// R17: erase start bit 6 triggers, self-clears
// R18: select bits cleared by hardware when busy falls
// R19: checksum select cleared when busy falls
// R20: user rom is 64 pages of 1024 bytes
// R21: erase sets every page bit to one
// R22: flash reads stall while busy
// R23: address register locked while busy
// R24: program-select word write latches and starts
// R25: forbidden program/erase refused, error flagged
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
module flash_program_erase_controller
	import flash_ctrl_pkg::*;
#(
	parameter int ROM_WORDS = ROM_BYTES / 4
) (
	// clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// apb register slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// flash space access from the cores and the programmer
	input wire logic fReq,
	input wire logic fWrite,
	input wire logic [1:0] fPath,
	input wire logic [31:0] fAddr,
	input wire logic [31:0] fWdata,
	output logic [31:0] fRdata,
	output logic fReady,
	output logic fDenied,
	// programmer mass erase request, one-cycle pulse
	input wire logic writerErase,
	// security level held in the code option at boot
	input wire logic [1:0] codeOptionLevel,
	// stored level to be written back to the code option
	output logic [1:0] storedLevel,
	// power saving mode to the flash macro
	output logic [1:0] powerSavingMode,
	// flash array
	output logic arrReq,
	output logic [1:0] arrOp,
	output logic [13:0] arrAddr,
	output logic [31:0] arrWdata,
	input wire logic [31:0] arrRdata,
	input wire logic arrAck
);

	typedef enum logic [2:0] {
		S_BOOT, S_IDLE, S_READ, S_PRECHECK, S_PROGRAM, S_PAGE_ERASE, S_MASS_ERASE, S_CHECKSUM
	} state_e;

	localparam logic [31:0] ROM_LIMIT = 32'(ROM_BYTES);
	localparam logic [13:0] LAST_WORD = 14'(ROM_WORDS - 1);

	state_e state_q;
	logic [1:0] psaveMode_q;
	logic programError_q;
	logic endOfOp_q;
	logic programSelect_q;
	logic pageEraseSelect_q;
	logic eraseStart_q;
	logic checksumSelect_q;
	logic [31:0] targetAddr_q;
	logic [15:0] checksum_q;
	logic [1:0] activeLevel_q;
	logic [1:0] storedLevel_q;
	logic massToZero_q;
	logic [13:0] wordAddr_q;
	logic [31:0] wordData_q;
	logic [31:0] fRdata_q;
	logic fReady_q;
	logic fDenied_q;

	// apb decode
	wire apbAccess = psel & penable;
	wire apbWr = apbAccess & pwrite;
	wire hitPower = paddr == OFS_POWER_SAVING_CTRL;
	wire hitState = paddr == OFS_OPERATION_STATE;
	wire hitSelect = paddr == OFS_OPERATION_SELECT;
	wire hitAddr = paddr == OFS_TARGET_ADDRESS;
	wire hitSum = paddr == OFS_ROM_CHECKSUM;
	wire hitSec = paddr == OFS_SECURITY_LEVEL;
	wire mapped = hitPower | hitState | hitSelect | hitAddr | hitSum | hitSec;
	wire idle = state_q == S_IDLE;
	wire busy = ~idle & (state_q != S_BOOT);

	wire keyOk = pwdata[31:KEY_LSB] == WRITE_UNLOCK_KEY;
	wire wrPower = apbWr & hitPower & keyOk; // see R14
	wire wrState = apbWr & hitState;
	wire wrSelect = apbWr & hitSelect;
	wire wrAddr = apbWr & hitAddr & ~busy; // see R23
	wire wrSec = apbWr & hitSec;

	// new select value as software would leave it
	wire newPerBit = pwdata[CT_PAGE_ERASE_SELECT];
	wire eraseTrig = wrSelect & pwdata[CT_ERASE_START] & newPerBit & idle; // see R17
	wire sumTrig = wrSelect & pwdata[CT_CHECKSUM_SELECT] & ~checksumSelect_q & idle;

	// security policy, judged on the level latched at boot
	wire lvlProtected = activeLevel_q != UNPROTECTED_LEVEL; // see R1
	wire fwLocked = activeLevel_q == PROTECT_LEVEL_THREE; // see R2
	wire addrLegal = fAddr < ROM_LIMIT; // see R20
	wire pageLegal = targetAddr_q < ROM_LIMIT; // see R20
	wire pathDebug = fPath == PATH_DEBUG;
	wire pathWriter = fPath == PATH_PROGRAMMER;
	wire readDenied = lvlProtected & (pathDebug | pathWriter); // see R2
	wire writeDenied = pathDebug ? lvlProtected : (pathWriter ? 1'b0 : fwLocked); // see R2

	// flash space request taken only when idle, so busy stalls it
	wire fTake = fReq & ~fReady_q & idle; // see R22
	wire fRead = fTake & ~fWrite;
	wire fWriteTake = fTake & fWrite;
	wire progStart = fWriteTake & programSelect_q & ~writeDenied & addrLegal; // see R24
	wire progRefused = fWriteTake & programSelect_q & (writeDenied | ~addrLegal); // see R25
	wire readStart = fRead & ~readDenied & addrLegal;
	wire fQuick = fTake & ~readStart & ~progStart;

	wire eraseGo = eraseTrig & pageLegal & ~fwLocked & ~fTake;
	wire eraseRefused = eraseTrig & (~pageLegal | fwLocked) & ~fTake; // see R25
	wire downgrade = wrSec & (pwdata[1:0] == UNPROTECTED_LEVEL) & lvlProtected;
	wire writerMass = writerErase & ~fwLocked; // see R3
	wire massGo = idle & ~fTake & ~eraseTrig & (downgrade | writerMass); // see R4
	wire sumGo = sumTrig & ~fTake & ~eraseTrig & ~massGo;

	// precheck outcome
	wire preErased = arrRdata == ERASED_WORD; // see R7
	wire preFail = (state_q == S_PRECHECK) & arrAck & ~preErased; // see R7
	wire opDone = arrAck & (state_q == S_PROGRAM || state_q == S_PAGE_ERASE || state_q == S_MASS_ERASE);
	wire sumLast = (state_q == S_CHECKSUM) & arrAck & (wordAddr_q == LAST_WORD);
	wire busyFall = preFail | opDone | sumLast; // see R16

	// sequencer
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			state_q <= S_BOOT;
		end else begin
			unique case (state_q)
				S_BOOT: state_q <= S_IDLE;
				S_IDLE: begin
					if (readStart) state_q <= S_READ;
					else if (progStart) state_q <= S_PRECHECK; // see R16
					else if (eraseGo) state_q <= S_PAGE_ERASE;
					else if (massGo) state_q <= S_MASS_ERASE;
					else if (sumGo) state_q <= S_CHECKSUM;
				end
				S_READ: if (arrAck) state_q <= S_IDLE;
				S_PRECHECK: if (arrAck) state_q <= preErased ? S_PROGRAM : S_IDLE; // see R7
				S_PROGRAM, S_PAGE_ERASE, S_MASS_ERASE: if (arrAck) state_q <= S_IDLE;
				S_CHECKSUM: if (sumLast) state_q <= S_IDLE;
			endcase
		end
	end

	// operation address and data; page erase uses the page-aligned word
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			wordAddr_q <= '0;
			wordData_q <= RESET_ZERO;
		end else if (readStart | progStart) begin
			wordAddr_q <= fAddr[15:2]; // see R6
			wordData_q <= fWdata; // see R24
		end else if (eraseGo) begin
			wordAddr_q <= {targetAddr_q[15:10], 8'h00}; // see R20
		end else if (sumGo | massGo) begin
			wordAddr_q <= '0;
		end else if ((state_q == S_CHECKSUM) & arrAck) begin
			wordAddr_q <= wordAddr_q + 14'h0001;
		end
	end

	// checksum: 16-bit sum of word halves over the user rom
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			checksum_q <= '0;
		end else if (sumGo) begin
			checksum_q <= '0;
		end else if ((state_q == S_CHECKSUM) & arrAck) begin
			checksum_q <= checksum_q + arrRdata[15:0] + arrRdata[31:16];
		end
	end

	// power saving mode, key guarded
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) psaveMode_q <= PSAVE_DISABLED;
		else if (wrPower) psaveMode_q <= pwdata[1:0]; // see R15
	end

	// status flags: hardware set wins over a software clear
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			programError_q <= 1'b0;
			endOfOp_q <= 1'b0;
		end else begin
			if (preFail | progRefused | eraseRefused) programError_q <= 1'b1; // see R8
			else if (wrState & ~pwdata[ST_PROGRAM_ERROR]) programError_q <= 1'b0; // see R8
			if (busyFall) endOfOp_q <= 1'b1; // see R9
			else if (wrState & ~pwdata[ST_END_OF_OPERATION]) endOfOp_q <= 1'b0;
		end
	end

	// control bits: software sets, busy falling clears
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			programSelect_q <= 1'b0;
			pageEraseSelect_q <= 1'b0;
			eraseStart_q <= 1'b0;
			checksumSelect_q <= 1'b0;
		end else if (busyFall) begin
			programSelect_q <= 1'b0; // see R18
			pageEraseSelect_q <= 1'b0; // see R18
			eraseStart_q <= 1'b0; // see R17
			checksumSelect_q <= 1'b0; // see R19
		end else if (wrSelect & ~busy) begin
			programSelect_q <= pwdata[CT_PROGRAM_SELECT];
			pageEraseSelect_q <= newPerBit;
			eraseStart_q <= eraseGo;
			checksumSelect_q <= sumGo;
		end
	end

	// target address register
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) targetAddr_q <= RESET_ZERO;
		else if (wrAddr) targetAddr_q <= pwdata; // see R23
	end

	// code security: active level caught once after reset release
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			activeLevel_q <= PROTECT_LEVEL_THREE;
			storedLevel_q <= PROTECT_LEVEL_THREE;
			massToZero_q <= 1'b0;
		end else if (state_q == S_BOOT) begin
			activeLevel_q <= codeOptionLevel; // see R1
			storedLevel_q <= codeOptionLevel;
		end else begin
			if (massGo) massToZero_q <= 1'b1;
			else if (opDone & (state_q == S_MASS_ERASE)) massToZero_q <= 1'b0;
			if (opDone & (state_q == S_MASS_ERASE) & massToZero_q) begin
				storedLevel_q <= UNPROTECTED_LEVEL; // see R4 R3
			end else if (wrSec & (pwdata[1:0] != UNPROTECTED_LEVEL) & idle) begin
				storedLevel_q <= pwdata[1:0]; // see R1
			end
		end
	end

	// flash space answer, one cycle after completion
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			fRdata_q <= RESET_ZERO;
			fReady_q <= 1'b0;
			fDenied_q <= 1'b0;
		end else begin
			fReady_q <= fQuick | ((state_q == S_READ) & arrAck); // see R22
			fDenied_q <= fTake & ((~fWrite & (readDenied | ~addrLegal)) | progRefused);
			if ((state_q == S_READ) & arrAck) fRdata_q <= arrRdata;
			else if (fTake & ~fWrite & readDenied) fRdata_q <= RESET_ZERO;
		end
	end

	// array request, held until acknowledged
	assign arrReq = state_q inside {S_READ, S_PRECHECK, S_PROGRAM, S_PAGE_ERASE, S_MASS_ERASE,
		S_CHECKSUM};
	assign arrOp = (state_q == S_PROGRAM) ? ARR_WRITE :
		(state_q == S_PAGE_ERASE) ? ARR_PAGE_ERASE : // see R21
		(state_q == S_MASS_ERASE) ? ARR_MASS_ERASE : ARR_READ; // see R12
	assign arrAddr = wordAddr_q;
	assign arrWdata = wordData_q;

	// register read mux; the checksum stays open whatever the level
	wire [31:0] rdPower = {16'h0000, 14'h0000, psaveMode_q};
	wire [31:0] rdState = 32'({endOfOp_q, 2'b00, programError_q, 1'b0, busy});
	wire [31:0] rdSelect = 32'({checksumSelect_q, eraseStart_q, 4'h0, pageEraseSelect_q,
		programSelect_q});
	wire [31:0] rdSum = {16'h0000, checksum_q}; // see R13
	wire [31:0] rdSec = 32'({activeLevel_q, 2'b00, storedLevel_q});
	assign prdata = hitPower ? rdPower :
		hitState ? rdState :
		hitSelect ? rdSelect :
		hitAddr ? targetAddr_q :
		hitSum ? rdSum :
		hitSec ? rdSec : RESET_ZERO;
	assign pready = 1'b1;
	assign pslverr = apbAccess & ~mapped;

	assign fRdata = fRdata_q;
	assign fReady = fReady_q;
	assign fDenied = fDenied_q;
	assign storedLevel = storedLevel_q;
	assign powerSavingMode = psaveMode_q;

endmodule : flash_program_erase_controller

// *** tb_top.sv ***
// tb_top: self-checking bench for the flash controller with a behavioural array
// assumes package, array model and checker are compiled before it
`timescale 1ns/1ps
module tb_top
	import flash_ctrl_pkg::*;
;
	localparam logic [32:0] DEN = 33'h100000000;
	localparam logic [32:0] ALL = 33'h1ffffffff;
	localparam logic [32:0] ONES = 33'h0ffffffff;
	logic mclk = 1'b0;
	logic nrst = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, fReq = 1'b0, fWrite = 1'b0;
	logic writerErase = 1'b0, slowAck = 1'b0, pready, pslverr, fReady, fDenied, arrReq, arrAck;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = '0, fAddr = '0, fWdata = '0, prdata, fRdata, arrRdata, arrWdata, a, w, rd;
	logic [1:0] fPath = 2'h0, codeOptionLevel = 2'h0, storedLevel, powerSavingMode, arrOp;
	logic [1:0] modes [2] = '{PSAVE_SLOW, PSAVE_DISABLED};
	logic [13:0] arrAddr;
	logic [65:0] aQ[$], fQ[$];
	int miscompares = 0, checked = 0;
	flash_program_erase_controller #(.ROM_WORDS(16)) i_dut (.mclk(mclk), .nrst(nrst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .fReq(fReq), .fWrite(fWrite), .fPath(fPath),
		.fAddr(fAddr), .fWdata(fWdata), .fRdata(fRdata), .fReady(fReady), .fDenied(fDenied),
		.writerErase(writerErase), .codeOptionLevel(codeOptionLevel), .storedLevel(storedLevel),
		.powerSavingMode(powerSavingMode), .arrReq(arrReq), .arrOp(arrOp), .arrAddr(arrAddr),
		.arrWdata(arrWdata), .arrRdata(arrRdata), .arrAck(arrAck));
	flash_array_model i_mem (.mclk(mclk), .slowAck(slowAck), .arrReq(arrReq), .arrOp(arrOp),
		.arrAddr(arrAddr), .arrWdata(arrWdata), .arrRdata(arrRdata), .arrAck(arrAck));
	initial forever #2 mclk = ~mclk;
	task automatic check(input logic [32:0] seen, input logic [65:0] e);
		checked++;
		if ((seen & e[65:33]) !== e[32:0]) begin
			miscompares++;
			$display("wrong value at %0t ns: seen %h expected %h", $time, seen & e[65:33], e[32:0]);
		end
	endtask : check
	task automatic stop_test();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : stop_test
	task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= ad;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk);
	endtask : apb
	task automatic regRd(input logic [7:0] ad, input logic [32:0] m, input logic [32:0] v);
		aQ.push_back({m, v});
		apb(1'b0, ad, '0);
	endtask : regRd
	// poll until busy drops; masked note always matches
	task automatic idle();
		do regRd(OFS_OPERATION_STATE, '0, '0); while (rd[ST_BUSY] !== 1'b0);
	endtask : idle
	task automatic fx(input logic wr, input logic [1:0] p, input logic [31:0] ad, input logic [31:0] d,
			input logic [65:0] e);
		fQ.push_back(e);
		fReq <= 1'b1;
		fWrite <= wr;
		fPath <= p;
		fAddr <= ad;
		fWdata <= d;
		do @(posedge mclk); while (fReady !== 1'b1);
		fReq <= 1'b0;
		@(posedge mclk);
	endtask : fx
	task automatic pgm(input logic [31:0] ad, input logic [31:0] d, input logic [65:0] e);
		apb(1'b1, OFS_OPERATION_SELECT, 32'h00000001);
		fx(1'b1, PATH_FIRMWARE, ad, d, e);
		idle();
	endtask : pgm
	task automatic boot(input logic [1:0] lv);
		nrst <= 1'b0;
		codeOptionLevel <= lv;
		repeat (2) @(posedge mclk);
		nrst <= 1'b1;
		repeat (2) @(posedge mclk);
	endtask : boot
	task automatic wipe();
		writerErase <= 1'b1;
		@(posedge mclk);
		writerErase <= 1'b0;
		idle();
	endtask : wipe
	always @(posedge mclk) begin
		if (psel && penable && pready && !pwrite) check({pslverr, prdata}, aQ.pop_front());
		if (fReady) check({fDenied, fRdata}, fQ.pop_front());
	end
	initial begin
		#100000;
		miscompares++;
		stop_test();
	end
	initial begin
		void'($urandom(32'h8d60c222));
		a = 32'($urandom_range(15)) << 2;
		w = $urandom() & 32'hfffffffe;
		boot(UNPROTECTED_LEVEL);
		regRd(OFS_OPERATION_STATE, ALL, '0);
		regRd(OFS_OPERATION_SELECT, ALL, '0);
		regRd(8'h1c, ALL, DEN);
		foreach (modes[i]) begin
			apb(1'b1, OFS_POWER_SAVING_CTRL, {WRITE_UNLOCK_KEY, 14'h0, modes[i]});
			apb(1'b1, OFS_POWER_SAVING_CTRL, {~WRITE_UNLOCK_KEY, 16'($urandom_range(65535))});
			regRd(OFS_POWER_SAVING_CTRL, ALL, {31'h0, modes[i]});
		end
		pgm(a, w, {DEN, 33'h0});
		regRd(OFS_OPERATION_STATE, 33'h25, 33'h20);
		regRd(OFS_OPERATION_SELECT, 33'h1, 33'h0);
		fx(1'b0, PATH_FIRMWARE, a, '0, {ALL, 1'b0, w});
		pgm(a, '0, {DEN, 33'h0});
		regRd(OFS_OPERATION_STATE, 33'h5, 33'h4);
		fx(1'b0, PATH_FIRMWARE, a, '0, {ALL, 1'b0, w});
		apb(1'b1, OFS_OPERATION_STATE, '0);
		regRd(OFS_OPERATION_STATE, 33'h4, 33'h0);
		pgm(32'h00010000, '0, {DEN, DEN});
		regRd(OFS_OPERATION_STATE, 33'h4, 33'h4);
		apb(1'b1, OFS_OPERATION_STATE, '0);
		slowAck <= 1'b1;
		apb(1'b1, OFS_OPERATION_SELECT, 32'h00000002);
		apb(1'b1, OFS_TARGET_ADDRESS, a);
		apb(1'b1, OFS_OPERATION_SELECT, 32'h00000042);
		regRd(OFS_OPERATION_STATE, 33'h1, 33'h1);
		apb(1'b1, OFS_TARGET_ADDRESS, a ^ 32'h00000400);
		regRd(OFS_TARGET_ADDRESS, ALL, {1'b0, a});
		fx(1'b0, PATH_FIRMWARE, a, '0, {ALL, ONES});
		idle();
		slowAck <= 1'b0;
		regRd(OFS_OPERATION_SELECT, 33'hc3, 33'h0);
		boot(PROTECT_LEVEL_TWO);
		fx(1'b0, PATH_DEBUG, a, '0, {DEN, DEN});
		fx(1'b0, PATH_PROGRAMMER, a, '0, {DEN, DEN});
		apb(1'b1, OFS_OPERATION_SELECT, 32'h00000080);
		idle();
		regRd(OFS_ROM_CHECKSUM, ALL, {17'h0, 16'(32 * 32'h0000ffff)});
		regRd(OFS_OPERATION_SELECT, 33'h80, 33'h0);
		pgm(a, w, {DEN, 33'h0});
		apb(1'b1, OFS_SECURITY_LEVEL, '0);
		idle();
		regRd(OFS_SECURITY_LEVEL, 33'h33, 33'h20);
		fx(1'b0, PATH_FIRMWARE, a, '0, {ALL, ONES});
		fx(1'b0, PATH_DEBUG, a, '0, {DEN, DEN});
		boot(PROTECT_LEVEL_THREE);
		pgm(a, '0, {DEN, DEN});
		regRd(OFS_OPERATION_STATE, 33'h4, 33'h4);
		wipe();
		regRd(OFS_SECURITY_LEVEL, 33'h33, 33'h33);
		boot(PROTECT_LEVEL_ONE);
		wipe();
		regRd(OFS_SECURITY_LEVEL, 33'h33, 33'h10);
		stop_test();
	end
endmodule : tb_top
